// ===== logic/lpbgc_pkg.sv
// Constants and types for the low-power background calibration sequencer
package lpbgc_pkg;
	localparam int unsigned NUM_CORES = 6;
	localparam int unsigned TRIM_W    = 16;
	localparam int unsigned DLY_W     = 16;
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_DELAY     = 8'h04;
	localparam logic [7:0] ADDR_STATUS    = 8'h08;
	localparam logic [7:0] ADDR_TRIM_SEL  = 8'h0C;
	localparam logic [7:0] ADDR_TRIM_DATA = 8'h10;
	localparam int CB_LOWPOWER_CAL_ENABLE    = 0;
	localparam int CB_MANUAL   = 1;
	localparam int CB_SW_TRIG  = 2;
	localparam int CB_TRIG_SRC = 3;
	localparam int CB_BG_EN    = 4;
	localparam int CB_FG_OS    = 5;
	localparam int CB_BG_OS    = 6;
	localparam int CB_SPARE_OFFSET_REFERENCE    = 7;
	localparam int CB_STAT_SEL = 8;
	localparam int SB_FOREGROUND_DONE_FLAG  = 0;
	localparam int SB_FINISHED = 1;
	localparam int SB_STAT_PIN = 2;
	localparam int SB_STATE    = 4;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0004;
	localparam logic [31:0] DELAY_RST = 32'h0010_0010;
	localparam logic [TRIM_W-1:0] OFS_RST  = 16'h0800;
	localparam logic [TRIM_W-1:0] GAIN_RST = 16'h0800;
	localparam logic [TRIM_W-1:0] FS_RST   = 16'hA000;
	localparam logic [1:0] TK_OFFSET = 2'h0;
	localparam logic [1:0] TK_GAIN   = 2'h1;
	localparam logic [1:0] TK_FS     = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_FG    = 3'h1,
		ST_SLEEP = 3'h2,
		ST_WAKE  = 3'h3,
		ST_CAL   = 3'h4,
		ST_HOLD  = 3'h5
	} lpbgc_state_t;
endpackage

// ===== logic/lpbgc_if.sv
// Link between calibration controller and converter sequencer
`timescale 1ns/1ps
interface lpbgc_if;
	import lpbgc_pkg::*;
	logic              cal_trigger_pin;
	logic              software_cal_trigger;
	logic              trigger_source_select;
	logic              lowpower_cal_enable;
	logic              manual_trigger_mode;
	logic [DLY_W-1:0]  spare_sleep_delay;
	logic [DLY_W-1:0]  spare_wake_delay;
	logic              background_cal_enable;
	logic              foreground_offset_enable;
	logic              background_offset_enable;
	logic              spare_offset_reference;
	logic              cal_status_sel;
	logic              trim_we;
	logic [1:0]        trim_kind;
	logic [2:0]        trim_core;
	logic [TRIM_W-1:0] trim_wdata;
	logic [TRIM_W-1:0] trim_rdata;
	logic              cal_status_pin;
	logic              foreground_done_flag;
	logic              spare_cal_finished;
	logic [2:0]        seq_state;
	modport dev (
		input  cal_trigger_pin, software_cal_trigger, trigger_source_select,
		input  lowpower_cal_enable, manual_trigger_mode, spare_sleep_delay,
		input  spare_wake_delay, background_cal_enable, foreground_offset_enable,
		input  background_offset_enable, spare_offset_reference, cal_status_sel,
		input  trim_we, trim_kind, trim_core, trim_wdata,
		output trim_rdata, cal_status_pin, foreground_done_flag,
		output spare_cal_finished, seq_state
	);
	modport ctl (
		output cal_trigger_pin, software_cal_trigger, trigger_source_select,
		output lowpower_cal_enable, manual_trigger_mode, spare_sleep_delay,
		output spare_wake_delay, background_cal_enable, foreground_offset_enable,
		output background_offset_enable, spare_offset_reference, cal_status_sel,
		output trim_we, trim_kind, trim_core, trim_wdata,
		input  trim_rdata, cal_status_pin, foreground_done_flag,
		input  spare_cal_finished, seq_state
	);
endinterface

// ===== logic/lpbgc_device.sv
// Converter-side low-power background calibration sequencer and trims
`timescale 1ns/1ps
module lpbgc_device
	import lpbgc_pkg::*;
#(
	parameter int unsigned CORES_PRESENT = 6,
	parameter int unsigned NUM_GROUPS    = 2,
	parameter int unsigned DLY_SHIFT     = 4
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	lpbgc_if.dev                              link,
	input  wire logic                         cal_done_i,
	input  wire logic                         ofs_valid_i,
	input  wire logic [2:0]                   ofs_core_i,
	input  wire logic [TRIM_W-1:0]            ofs_value_i,
	output logic      [NUM_GROUPS-1:0]        spare_power_o,
	output logic                              spare_cal_run_o,
	output logic                              fg_cal_run_o,
	output logic                              offset_cal_o,
	output logic                              offset_ref_spare_o,
	output logic      [NUM_GROUPS-1:0]        swap_sel_o,
	output logic      [TRIM_W-1:0]            full_scale_o,
	output logic      [NUM_CORES*TRIM_W-1:0]  offset_trim_o,
	output logic      [NUM_CORES*TRIM_W-1:0]  gain_trim_o
);
	localparam int unsigned CNT_W = DLY_W + DLY_SHIFT;

	initial begin
		if (CORES_PRESENT < 3 || CORES_PRESENT > NUM_CORES ||
				NUM_GROUPS < 1 || NUM_GROUPS > 2 || DLY_SHIFT > 16)
			$error("lpbgc_device: unsupported parameters");
	end

	lpbgc_state_t      state_q, state_d;
	logic [2:0]        pin_sync_q;
	logic              pin_q;
	logic              trig;
	logic              bg_en_q;
	logic              trig_prev_q;
	logic              fg_req_q;
	logic [CNT_W-1:0]  cnt_q;
	logic              load_sleep, load_wake, swap_now, cal_end;
	logic              lp_auto, lp_man;
	logic [TRIM_W-1:0] ofs_q  [NUM_CORES];
	logic [TRIM_W-1:0] gain_q [NUM_CORES];
	logic [TRIM_W-1:0] fs_q;
	logic              ofs_busy;

	// Pin crosses in; change taken once stages 2 and 3 agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_sync_q <= 3'h7;
			pin_q      <= 1'b1;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], link.cal_trigger_pin};
			if (pin_sync_q[1] == pin_sync_q[2])
				pin_q <= pin_sync_q[2];
		end
	end

	assign trig    = link.trigger_source_select ? pin_q : link.software_cal_trigger;
	assign lp_auto = link.lowpower_cal_enable && !link.manual_trigger_mode;
	assign lp_man  = link.lowpower_cal_enable && link.manual_trigger_mode;
	assign cal_end = cal_done_i && state_q == ST_CAL;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bg_en_q     <= 1'b0;
			trig_prev_q <= 1'b1;
		end else begin
			bg_en_q     <= link.background_cal_enable;
			trig_prev_q <= trig;
		end
	end

	// Foreground pass at power-up, on trigger with background off, or before background with foreground offset enabled
	always_ff @(posedge clk_i) begin
		if (rst_i)
			fg_req_q <= 1'b1;
		else if (state_q == ST_IDLE && fg_req_q)
			fg_req_q <= 1'b0;
		// offset enable set ahead of background enable
		else if (link.background_cal_enable && !bg_en_q && link.foreground_offset_enable)
			fg_req_q <= 1'b1;
		else if (!link.background_cal_enable && trig && !trig_prev_q)
			fg_req_q <= 1'b1;
	end

	always_comb begin
		state_d    = state_q;
		load_sleep = 1'b0;
		load_wake  = 1'b0;
		swap_now   = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				// Wait one cycle after enable so a pending foreground request wins
				if (fg_req_q)
					state_d = ST_FG;
				else if (link.background_cal_enable && bg_en_q &&
						link.lowpower_cal_enable) begin
					state_d    = ST_SLEEP;
					load_sleep = 1'b1;
				end else if (link.background_cal_enable && bg_en_q)
					state_d = ST_CAL;
			end
			ST_FG: begin
				if (cal_done_i)
					state_d = ST_IDLE;
			end
			ST_SLEEP: begin
				// trigger high holds spare asleep; low wakes it
				if (lp_man && !trig) begin
					state_d   = ST_WAKE;
					load_wake = 1'b1;
				// sleep delay elapsed in auto mode
				end else if (lp_auto && cnt_q == '0) begin
					state_d   = ST_WAKE;
					load_wake = 1'b1;
				end
			end
			ST_WAKE: begin
				// settle for wake delay before calibrating
				// manual calibration starts after wake delay
				if (cnt_q == '0)
					state_d = ST_CAL;
			end
			ST_CAL: begin
				if (cal_done_i) begin
					// trigger still low, stay powered and calibrating
					if (lp_man && !trig)
						state_d = ST_HOLD;
					// otherwise swap at once; released core sleeps only in low-power mode
					else begin
						swap_now   = 1'b1;
						state_d    = link.lowpower_cal_enable ? ST_SLEEP : ST_CAL;
						load_sleep = link.lowpower_cal_enable;
					end
				end
			end
			ST_HOLD: begin
				// swap once done and trigger back high
				if (trig) begin
					swap_now   = 1'b1;
					state_d    = ST_SLEEP;
					load_sleep = 1'b1;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		// Leaving background mode abandons the spare pass
		if (!link.background_cal_enable && state_q != ST_IDLE && state_q != ST_FG) begin
			state_d  = ST_IDLE;
			swap_now = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// counters restart at each sleep or wake entry
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_q <= '0;
		else if (load_sleep)
			cnt_q <= {link.spare_sleep_delay, {DLY_SHIFT{1'b0}}};
		else if (load_wake)
			cnt_q <= {link.spare_wake_delay, {DLY_SHIFT{1'b0}}};
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	// one selection word changes in a single edge
	always_ff @(posedge clk_i) begin
		if (rst_i)
			swap_sel_o <= '0;
		else if (swap_now)
			swap_sel_o <= ~swap_sel_o;
	end

	// spare powered only when due; one spare per group
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			spare_power_o   <= '0;
			spare_cal_run_o <= 1'b0;
			fg_cal_run_o    <= 1'b0;
			offset_cal_o    <= 1'b0;
		end else begin
			spare_power_o   <= {NUM_GROUPS{state_d == ST_WAKE || state_d == ST_CAL ||
				state_d == ST_HOLD}};
			spare_cal_run_o <= state_d == ST_CAL || state_d == ST_HOLD;
			fg_cal_run_o    <= state_d == ST_FG;
			// foreground offset only in foreground pass
			// background offset in every spare pass
			offset_cal_o    <= (state_d == ST_FG && link.foreground_offset_enable) ||
				((state_d == ST_CAL || state_d == ST_HOLD) && link.background_offset_enable);
		end
	end

	// Set wins over clear on both flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.spare_cal_finished   <= 1'b0;
			link.foreground_done_flag <= 1'b0;
		end else begin
			if (cal_end)
				link.spare_cal_finished <= 1'b1;
			else if (load_wake)
				link.spare_cal_finished <= 1'b0;
			if (state_q == ST_FG && cal_done_i)
				link.foreground_done_flag <= 1'b1;
			else if (state_q == ST_IDLE && fg_req_q)
				link.foreground_done_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.cal_status_pin <= 1'b0;
			link.seq_state      <= 3'h0;
			offset_ref_spare_o  <= 1'b0;
		end else begin
			link.cal_status_pin <= link.cal_status_sel ? link.spare_cal_finished
				: link.foreground_done_flag;
			link.seq_state      <= state_q;
			offset_ref_spare_o  <= link.spare_offset_reference;
		end
	end

	assign ofs_busy = link.foreground_offset_enable || link.background_offset_enable;

	// Trim store; absent cores ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_CORES; i++) begin
				ofs_q[i]  <= OFS_RST;
				gain_q[i] <= GAIN_RST;
			end
			fs_q <= FS_RST;
		end else begin
			// calibration results own the offset trims
			if (ofs_valid_i && offset_cal_o && 32'(ofs_core_i) < CORES_PRESENT)
				ofs_q[ofs_core_i] <= ofs_value_i;
			else if (link.trim_we && link.trim_kind == TK_OFFSET && !ofs_busy &&
					32'(link.trim_core) < CORES_PRESENT)
				ofs_q[link.trim_core] <= link.trim_wdata;
			// gain trims only change by software
			if (link.trim_we && link.trim_kind == TK_GAIN &&
					32'(link.trim_core) < CORES_PRESENT)
				gain_q[link.trim_core] <= link.trim_wdata;
			if (link.trim_we && link.trim_kind == TK_FS)
				fs_q <= link.trim_wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			link.trim_rdata <= '0;
		else if (link.trim_kind == TK_FS)
			link.trim_rdata <= fs_q;
		else if (32'(link.trim_core) >= CORES_PRESENT)
			link.trim_rdata <= '0;
		else if (link.trim_kind == TK_GAIN)
			link.trim_rdata <= gain_q[link.trim_core];
		else
			link.trim_rdata <= ofs_q[link.trim_core];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			full_scale_o <= FS_RST;
		else
			full_scale_o <= fs_q;
	end

	for (genvar g = 0; g < NUM_CORES; g++) begin : g_trim_out
		assign offset_trim_o[g*TRIM_W +: TRIM_W] = ofs_q[g];
		assign gain_trim_o[g*TRIM_W +: TRIM_W]   = gain_q[g];
	end
endmodule

// ===== logic/lpbgc_ctrl.sv
// System-side calibration controller with classic Wishbone registers
`timescale 1ns/1ps
module lpbgc_ctrl
	import lpbgc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        trig_pin_i,
	output logic             cal_status_o,
	lpbgc_if.ctl             link
);
	logic [31:0] ctrl_q;
	logic [31:0] delay_q;
	logic [5:0]  tsel_q;
	logic [2:0]  stat_sync_q;
	logic        req;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		return r;
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q  <= CTRL_RST;
			delay_q <= DELAY_RST;
			tsel_q  <= '0;
		end else if (req && wb_we_i) begin
			unique case (wb_adr_i)
				ADDR_CTRL:     ctrl_q  <= merge(ctrl_q, wb_dat_i, wb_sel_i);
				ADDR_DELAY:    delay_q <= merge(delay_q, wb_dat_i, wb_sel_i);
				ADDR_TRIM_SEL: if (wb_sel_i[0]) tsel_q <= wb_dat_i[5:0];
				default:       ;
			endcase
		end
	end

	// Data write with both low byte lanes selected fires one trim strobe toward the converter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.trim_we    <= 1'b0;
			link.trim_wdata <= '0;
		end else begin
			link.trim_we    <= req && wb_we_i && wb_adr_i == ADDR_TRIM_DATA &&
				wb_sel_i[1:0] == 2'h3;
			link.trim_wdata <= wb_dat_i[TRIM_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				ADDR_CTRL:      wb_dat_o <= ctrl_q;
				ADDR_DELAY:     wb_dat_o <= delay_q;
				ADDR_STATUS:    wb_dat_o <= {25'h0, link.seq_state, 1'b0,
					cal_status_o, link.spare_cal_finished, link.foreground_done_flag};
				ADDR_TRIM_SEL:  wb_dat_o <= {26'h0, tsel_q};
				ADDR_TRIM_DATA: wb_dat_o <= {16'h0, link.trim_rdata};
				default:        wb_dat_o <= '0;
			endcase
		end
	end

	// Status pin arrives from off-chip; filtered like any pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_sync_q  <= '0;
			cal_status_o <= 1'b0;
		end else begin
			stat_sync_q <= {stat_sync_q[1:0], link.cal_status_pin};
			if (stat_sync_q[1] == stat_sync_q[2])
				cal_status_o <= stat_sync_q[2];
		end
	end

	// system times the trigger through pin or software bit
	always_ff @(posedge clk_i) begin
		if (rst_i)
			link.cal_trigger_pin <= 1'b1;
		else
			link.cal_trigger_pin <= trig_pin_i;
	end

	assign link.software_cal_trigger     = ctrl_q[CB_SW_TRIG];
	assign link.trigger_source_select    = ctrl_q[CB_TRIG_SRC];
	assign link.lowpower_cal_enable      = ctrl_q[CB_LOWPOWER_CAL_ENABLE];
	assign link.manual_trigger_mode      = ctrl_q[CB_MANUAL];
	assign link.background_cal_enable    = ctrl_q[CB_BG_EN];
	assign link.foreground_offset_enable = ctrl_q[CB_FG_OS];
	assign link.background_offset_enable = ctrl_q[CB_BG_OS];
	assign link.spare_offset_reference   = ctrl_q[CB_SPARE_OFFSET_REFERENCE];
	assign link.cal_status_sel           = ctrl_q[CB_STAT_SEL];
	assign link.spare_sleep_delay        = delay_q[DLY_W-1:0];
	assign link.spare_wake_delay         = delay_q[31:16];
	assign link.trim_core                = tsel_q[2:0];
	assign link.trim_kind                = tsel_q[5:4];
endmodule

// ===== test/lpbgc_checker.sv
// Concurrent checks on the link between controller and sequencer
`timescale 1ns/1ps
module lpbgc_checker
	import lpbgc_pkg::*;
#(
	parameter int unsigned DLY_SHIFT = 4
) (
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             cal_trigger_pin,
	input wire logic             software_cal_trigger,
	input wire logic             trigger_source_select,
	input wire logic             lowpower_cal_enable,
	input wire logic             manual_trigger_mode,
	input wire logic [DLY_W-1:0] spare_sleep_delay,
	input wire logic [DLY_W-1:0] spare_wake_delay,
	input wire logic             background_cal_enable,
	input wire logic             cal_status_sel,
	input wire logic             cal_status_pin,
	input wire logic             foreground_done_flag,
	input wire logic             spare_cal_finished,
	input wire logic [2:0]       seq_state
);
	logic [2:0]  prev_q;
	logic [31:0] run_q;
	logic        trig;
	logic [31:0] slp;
	logic [31:0] wak;
	assign trig = trigger_source_select ? cal_trigger_pin : software_cal_trigger;
	assign slp = 32'(spare_sleep_delay) << DLY_SHIFT;
	assign wak = 32'(spare_wake_delay) << DLY_SHIFT;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_q <= 3'h0;
		end else begin
			prev_q <= seq_state;
		end
	end
	// Length of the run that ended last cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || seq_state != prev_q) begin
			run_q <= 32'h1;
		end else begin
			run_q <= run_q + 32'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sleep_time_a: assert property (
		prev_q == ST_SLEEP && seq_state == ST_WAKE && !manual_trigger_mode
		|-> run_q >= slp && run_q <= slp + 32'h2) else $error("sleep length wrong");
	wake_time_a: assert property (
		prev_q == ST_WAKE && seq_state == ST_CAL
		|-> run_q >= wak && run_q <= wak + 32'h2) else $error("wake length wrong");
	manual_sleep_a: assert property (
		(manual_trigger_mode && lowpower_cal_enable && background_cal_enable && trig)[*6]
		##0 seq_state == ST_SLEEP |=> seq_state == ST_SLEEP) else $error("woke while held");
	wake_entry_a: assert property (
		seq_state == ST_WAKE && prev_q != ST_WAKE |-> prev_q == ST_SLEEP)
		else $error("wake not from sleep");
	hold_manual_a: assert property (
		seq_state == ST_HOLD |-> manual_trigger_mode && spare_cal_finished)
		else $error("bad hold state");
	auto_swap_a: assert property (
		!manual_trigger_mode && lowpower_cal_enable && seq_state == ST_CAL
		|=> seq_state != ST_HOLD) else $error("auto mode held swap");
	status_sel_a: assert property (
		cal_status_sel && $past(cal_status_sel) |-> cal_status_pin == $past(spare_cal_finished))
		else $error("status pin not finished flag");
	status_fg_a: assert property (
		!cal_status_sel && !$past(cal_status_sel)
		|-> cal_status_pin == $past(foreground_done_flag)) else $error("status pin not foreground_done_flag");
	fg_flag_a: assert property (
		seq_state == ST_FG && prev_q == ST_FG |-> !$past(foreground_done_flag))
		else $error("foreground_done_flag during pass");
	cover property (seq_state == ST_HOLD);
	cover property (prev_q == ST_SLEEP && seq_state == ST_WAKE);
	cover property (cal_status_sel && cal_status_pin);
endmodule

// ===== test/test_lowpower_bg_cal_control.sv
// Self-checking bench for controller and sequencer joined by the link
`timescale 1ns/1ps
module test_lowpower_bg_cal_control;
	import lpbgc_pkg::*;
	typedef struct packed {logic we; logic [7:0] adr; logic [31:0] dat;} lpbgc_row_t;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        trig_pin = 1'b1;
	logic        cal_done = 1'b0;
	logic        ofs_valid = 1'b0;
	logic [2:0]  ofs_core = 3'h0;
	logic [15:0] ofs_value = 16'h0;
	logic        stat_o, spare_run, fg_run, ofs_cal, ref_spare;
	logic [1:0]  power, swap, sw;
	logic [15:0] full_scale;
	logic [95:0] ofs_trim, gain_trim;
	int          n_fail = 0;
	int          num_checks = 0;
	// Reads carry the expected value in dat
	lpbgc_row_t  rows [0:14] = '{
		'{1'b0, ADDR_STATUS, 32'h5}, '{1'b0, ADDR_DELAY, 32'h0010_0010},
		'{1'b1, ADDR_DELAY, 32'h0006_0008}, '{1'b0, ADDR_DELAY, 32'h0006_0008},
		'{1'b1, ADDR_TRIM_SEL, 32'h12}, '{1'b1, ADDR_TRIM_DATA, 32'h1234},
		'{1'b0, ADDR_TRIM_DATA, 32'h1234}, '{1'b1, ADDR_TRIM_SEL, 32'h20},
		'{1'b0, ADDR_TRIM_DATA, 32'hA000}, '{1'b1, ADDR_TRIM_SEL, 32'h16},
		'{1'b1, ADDR_TRIM_DATA, 32'hBEEF}, '{1'b0, ADDR_TRIM_DATA, 32'h0},
		'{1'b1, 8'h20, 32'hFFFF_FFFF}, '{1'b0, 8'h20, 32'h0}, '{1'b0, ADDR_CTRL, 32'h4}};
	lpbgc_if link_if ();
	lpbgc_device #(.DLY_SHIFT(0)) lpbgc_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(link_if),
		.cal_done_i(cal_done), .ofs_valid_i(ofs_valid), .ofs_core_i(ofs_core),
		.ofs_value_i(ofs_value), .spare_power_o(power), .spare_cal_run_o(spare_run),
		.fg_cal_run_o(fg_run), .offset_cal_o(ofs_cal), .offset_ref_spare_o(ref_spare),
		.swap_sel_o(swap), .full_scale_o(full_scale), .offset_trim_o(ofs_trim),
		.gain_trim_o(gain_trim));
	lpbgc_ctrl lpbgc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .trig_pin_i(trig_pin), .cal_status_o(stat_o),
		.link(link_if));
	lpbgc_checker #(.DLY_SHIFT(0)) lpbgc_checker_i (.clk_i(clk_i), .rst_i(rst_i),
		.cal_trigger_pin(link_if.cal_trigger_pin),
		.software_cal_trigger(link_if.software_cal_trigger),
		.trigger_source_select(link_if.trigger_source_select),
		.lowpower_cal_enable(link_if.lowpower_cal_enable),
		.manual_trigger_mode(link_if.manual_trigger_mode),
		.spare_sleep_delay(link_if.spare_sleep_delay), .spare_wake_delay(link_if.spare_wake_delay),
		.background_cal_enable(link_if.background_cal_enable),
		.cal_status_sel(link_if.cal_status_sel), .cal_status_pin(link_if.cal_status_pin),
		.foreground_done_flag(link_if.foreground_done_flag),
		.spare_cal_finished(link_if.spare_cal_finished), .seq_state(link_if.seq_state));
	always #2 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		chk({31'h0, wb_ack}, 32'h1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	// Bounded wait for a sequencer state
	task automatic st(input logic [2:0] s);
		int n;
		n = 0;
		while (link_if.seq_state !== s && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		chk(link_if.seq_state, s);
	endtask
	task automatic pulse_done();
		@(posedge clk_i);
		cal_done <= 1'b1;
		@(posedge clk_i);
		cal_done <= 1'b0;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		chk(32'h0, 32'h1);
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		chk(full_scale, 32'hA000);
		chk(gain_trim[15:0], 32'h0800);
		chk(link_if.cal_trigger_pin, 32'h1);
		rst_i <= 1'b0;
		st(ST_FG);
		pulse_done();
		st(ST_IDLE);
		// Status pin needs its filter delay before the status read
		repeat (8) @(posedge clk_i);
		foreach (rows[i]) begin
			if (rows[i].we) wr(rows[i].adr, rows[i].dat);
			else rd(rows[i].adr, rows[i].dat);
		end
		chk(gain_trim[47:32], 32'h1234);
		wr(ADDR_CTRL, 32'h24);
		wr(ADDR_CTRL, 32'h34);
		st(ST_FG);
		chk(ofs_cal, 32'h1);
		@(posedge clk_i);
		ofs_valid <= 1'b1;
		ofs_core <= 3'h4;
		ofs_value <= 16'h0ABC;
		@(posedge clk_i);
		ofs_valid <= 1'b0;
		wr(ADDR_TRIM_SEL, 32'h04);
		wr(ADDR_TRIM_DATA, 32'h1111);
		pulse_done();
		st(ST_CAL);
		chk(ofs_trim[79:64], 32'h0ABC);
		chk(link_if.foreground_done_flag, 32'h1);
		sw = ~swap;
		pulse_done();
		repeat (2) @(posedge clk_i);
		chk(swap, sw);
		wr(ADDR_CTRL, 32'h04);
		st(ST_IDLE);
		wr(ADDR_CTRL, 32'hD5);
		st(ST_SLEEP);
		chk(power, 32'h0);
		chk(ref_spare, 32'h1);
		st(ST_WAKE);
		chk(power, 32'h3);
		st(ST_CAL);
		chk(ofs_cal, 32'h1);
		sw = ~swap;
		pulse_done();
		st(ST_SLEEP);
		chk(swap, sw);
		chk(power, 32'h0);
		st(ST_WAKE);
		wr(ADDR_CTRL, 32'h04);
		st(ST_IDLE);
		wr(ADDR_CTRL, 32'h117);
		st(ST_SLEEP);
		repeat (40) @(posedge clk_i);
		chk(link_if.seq_state, ST_SLEEP);
		sw = swap;
		wr(ADDR_CTRL, 32'h113);
		st(ST_WAKE);
		st(ST_CAL);
		pulse_done();
		st(ST_HOLD);
		repeat (8) @(posedge clk_i);
		chk(stat_o, 32'h1);
		chk(power, 32'h3);
		chk(swap, sw);
		sw = ~swap;
		wr(ADDR_CTRL, 32'h117);
		st(ST_SLEEP);
		chk(swap, sw);
		wr(ADDR_CTRL, 32'h11F);
		@(posedge clk_i);
		trig_pin <= 1'b0;
		st(ST_WAKE);
		st(ST_CAL);
		trig_pin <= 1'b1;
		repeat (8) @(posedge clk_i);
		sw = ~swap;
		pulse_done();
		st(ST_SLEEP);
		chk(swap, sw);
		wrap_up();
	end
endmodule
